// >>> smux_audio_path.sv
// Purpose: Digital audio path: host stream check, sample multiplexing, monitor delay
// Assumes: Word clock arrives from outside and marks single-speed frames
// Notes: Host words come in time order, all channels of one instant together

package smux_audio_pkg;
	localparam int SAMPLE_W = 24;
	localparam int SLOTS = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int LINES = 4;
	localparam int MON_DELAY = 3;
	localparam int CLK_HZ = 250000000;
	localparam int CARRIER_MAX_HZ = 48000;
	localparam int FRAME_MIN_CYCLES = (CLK_HZ + CARRIER_MAX_HZ - 1) / CARRIER_MAX_HZ;
	localparam int GAP_W = 20;
	localparam logic [1:0] RATE_CODE_DOUBLE = 2'h1;
	localparam logic [1:0] RATE_CODE_QUAD = 2'h2;
	localparam logic [15:0] ERR_COUNT_RST = 16'h0000;
	localparam logic [7:0] POS_RST = 8'h00;
	localparam logic [2:0] SLOT_RST = 3'h0;
	// Last word index of a frame and the ceiling of the error count
	localparam logic [2:0] WORD_LAST = 3'h7;
	localparam logic [15:0] ERR_COUNT_MAX = 16'hffff;

	typedef enum logic [1:0] {RATE_SINGLE, RATE_DOUBLE, RATE_QUAD} rate_t;
	typedef enum logic {ST_RUN, ST_FILL} fill_state_t;

	// Slot of the k-th word of a frame (time-major arrival order)
	function automatic logic [2:0] slot_of(input logic [2:0] k, input rate_t r);
		case (r)
			RATE_DOUBLE: slot_of = {k[1:0], k[2]};
			RATE_QUAD: slot_of = {k[0], k[2:1]};
			default: slot_of = k;
		endcase
	endfunction : slot_of
endpackage : smux_audio_pkg

`timescale 1ns/100ps
module smux_audio_path import smux_audio_pkg::*; #(
	parameter int FRAME_MIN = FRAME_MIN_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [1:0] rate_sel_in,
	input wire logic word_clk_in,
	input wire logic usb_valid_in,
	output logic usb_ready_out,
	input wire logic [SAMPLE_W-1:0] usb_data_in,
	input wire logic usb_parity_in,
	input wire logic [7:0] usb_pos_in,
	output logic usb_error_out,
	output logic [15:0] usb_error_count_out,
	output logic dropout_out,
	output logic underrun_out,
	output logic [SLOTS*SAMPLE_W-1:0] port_slots_out,
	output logic port_frame_out,
	output logic [LINES*SAMPLE_W-1:0] aes_left_out,
	output logic [LINES*SAMPLE_W-1:0] aes_right_out,
	output logic [1:0] rate_active_out,
	input wire logic mon_valid_in,
	input wire logic [SAMPLE_W-1:0] mon_data_in,
	output logic mon_valid_out,
	output logic [SAMPLE_W-1:0] mon_data_out
);
	// ----------------------------------------------------------------
	// Host stream check and drop-out refill
	// ----------------------------------------------------------------
	fill_state_t state_q;
	logic [7:0] exp_pos_q;
	logic [7:0] fill_cnt_q;
	logic [15:0] err_cnt_q;
	logic err_q;
	logic drop_q;
	logic fifo_wr_ready;

	// A position gap means host words were lost; zeros refill the gap
	wire logic pos_match = (usb_pos_in == exp_pos_q);
	wire logic parity_ok = ((^usb_data_in) == usb_parity_in);
	wire logic take_word = (state_q == ST_RUN) && usb_valid_in && pos_match && fifo_wr_ready;
	wire logic start_fill = (state_q == ST_RUN) && usb_valid_in && !pos_match;
	wire logic fill_push = (state_q == ST_FILL) && fifo_wr_ready;
	wire logic fifo_wr_valid = take_word || fill_push;
	// Corrupt words are replaced by silence so the slot order is kept
	wire logic [SAMPLE_W-1:0] fifo_wr_data = (take_word && parity_ok) ? usb_data_in : '0;

	assign usb_ready_out = (state_q == ST_RUN) && pos_match && fifo_wr_ready;
	assign usb_error_out = err_q;
	assign usb_error_count_out = err_cnt_q;
	assign dropout_out = drop_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= ST_RUN;
			exp_pos_q <= POS_RST;
			fill_cnt_q <= POS_RST;
			err_cnt_q <= ERR_COUNT_RST;
			err_q <= 1'b0;
			drop_q <= 1'b0;
		end else begin
			err_q <= take_word && !parity_ok;
			drop_q <= start_fill;
			// Count saturates so a long faulty run cannot wrap to zero
			if (take_word && !parity_ok && (err_cnt_q != ERR_COUNT_MAX)) begin
				err_cnt_q <= err_cnt_q + 16'h0001;
			end
			case (state_q)
				ST_RUN: begin
					if (take_word) begin
						exp_pos_q <= exp_pos_q + 8'h01;
					end else if (start_fill) begin
						// Gap length is taken mod 256, as positions wrap
						fill_cnt_q <= usb_pos_in - exp_pos_q;
						state_q <= ST_FILL;
					end
				end
				ST_FILL: begin
					if (fill_push) begin
						exp_pos_q <= exp_pos_q + 8'h01;
						fill_cnt_q <= fill_cnt_q - 8'h01;
						if (fill_cnt_q == 8'h01) begin
							state_q <= ST_RUN;
						end
					end
				end
				default: state_q <= ST_RUN;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sample buffer
	// ----------------------------------------------------------------
	logic fifo_rd_valid;
	logic [SAMPLE_W-1:0] fifo_rd_data;
	logic [2:0] word_idx_q;
	logic stage_full_q;
	wire logic fifo_rd_ready;

	// Depth covers a frame of words plus refill zeros
	sample_fifo #(
		.WIDTH(SAMPLE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.wr_valid_in(fifo_wr_valid),
		.wr_ready_out(fifo_wr_ready),
		.wr_data_in(fifo_wr_data),
		.rd_valid_out(fifo_rd_valid),
		.rd_ready_in(fifo_rd_ready),
		.rd_data_out(fifo_rd_data)
	);

	// ----------------------------------------------------------------
	// Word clock synchroniser and frame rate guard
	// ----------------------------------------------------------------
	// Three flops; a level counts once the second and third agree
	logic wc_s1_q;
	logic wc_s2_q;
	logic wc_s3_q;
	logic wc_lvl_q;
	logic [GAP_W-1:0] gap_cnt_q;

	wire logic wc_agree = (wc_s2_q == wc_s3_q);
	wire logic wc_rise = wc_agree && wc_s3_q && !wc_lvl_q;
	wire logic gap_ok = (gap_cnt_q >= GAP_W'(FRAME_MIN - 1));
	// Rises sooner than FRAME_MIN cycles after a tick are dropped, capping the frame rate
	wire logic frame_tick = wc_rise && gap_ok;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wc_s1_q <= 1'b0;
			wc_s2_q <= 1'b0;
			wc_s3_q <= 1'b0;
			wc_lvl_q <= 1'b0;
			gap_cnt_q <= '0;
		end else begin
			wc_s1_q <= word_clk_in;
			wc_s2_q <= wc_s1_q;
			wc_s3_q <= wc_s2_q;
			if (wc_agree) begin
				wc_lvl_q <= wc_s3_q;
			end
			if (frame_tick) begin
				gap_cnt_q <= '0;
			end else if (!gap_ok) begin
				gap_cnt_q <= gap_cnt_q + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Frame assembly with sample multiplexing
	// ----------------------------------------------------------------
	rate_t rate_q;
	logic [SAMPLE_W-1:0] stage_q [SLOTS];
	logic [SAMPLE_W-1:0] slot_q [SLOTS];
	logic frame_q;
	logic under_q;

	wire rate_t rate_req = (rate_sel_in == RATE_CODE_QUAD) ? RATE_QUAD :
		(rate_sel_in == RATE_CODE_DOUBLE) ? RATE_DOUBLE : RATE_SINGLE;
	// No word leaves the buffer in a tick cycle, as staging is cleared then
	assign fifo_rd_ready = !stage_full_q && !frame_tick;
	wire logic pop_word = fifo_rd_valid && fifo_rd_ready;
	// Arrival is time-major; the slot map groups each channel's samples
	wire logic [2:0] slot_sel = slot_of(word_idx_q, rate_q);

	assign port_frame_out = frame_q;
	assign underrun_out = under_q;
	assign rate_active_out = rate_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rate_q <= RATE_SINGLE;
			word_idx_q <= SLOT_RST;
			stage_full_q <= 1'b0;
			frame_q <= 1'b0;
			under_q <= 1'b0;
			for (int i = 0; i < SLOTS; i++) begin
				stage_q[i] <= '0;
				slot_q[i] <= '0;
			end
		end else begin
			frame_q <= frame_tick;
			// Unfilled slots stay zero and the frame is flagged as underrun
			under_q <= frame_tick && !stage_full_q;
			if (frame_tick) begin
				// Rate changes only at a frame boundary to keep groups intact
				rate_q <= rate_req;
				word_idx_q <= SLOT_RST;
				stage_full_q <= 1'b0;
				for (int i = 0; i < SLOTS; i++) begin
					slot_q[i] <= stage_q[i];
					stage_q[i] <= '0;
				end
			end else if (pop_word) begin
				stage_q[slot_sel] <= fifo_rd_data;
				word_idx_q <= word_idx_q + 3'h1;
				if (word_idx_q == WORD_LAST) begin
					stage_full_q <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Port and line outputs
	// ----------------------------------------------------------------
	// Slot registers feed both the port and the lines in every mode
	genvar g;
	generate
		for (g = 0; g < SLOTS; g++) begin : g_port
			assign port_slots_out[g*SAMPLE_W +: SAMPLE_W] = slot_q[g];
		end
		for (g = 0; g < LINES; g++) begin : g_line
			// At double and quad rate left holds the earlier (even) sample, right the later one
			assign aes_left_out[g*SAMPLE_W +: SAMPLE_W] = slot_q[2*g];
			assign aes_right_out[g*SAMPLE_W +: SAMPLE_W] = slot_q[2*g+1];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Monitor path delay
	// ----------------------------------------------------------------
	logic [SAMPLE_W-1:0] mon_dly_q [MON_DELAY];
	logic [SAMPLE_W-1:0] mon_out_q;
	logic mon_vld_q;

	assign mon_valid_out = mon_vld_q;
	assign mon_data_out = mon_out_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mon_out_q <= '0;
			mon_vld_q <= 1'b0;
			for (int i = 0; i < MON_DELAY; i++) begin
				mon_dly_q[i] <= '0;
			end
		end else begin
			// Samples advance only on valid, so the delay counts samples, not clocks
			mon_vld_q <= mon_valid_in;
			if (mon_valid_in) begin
				mon_dly_q[0] <= mon_data_in;
				for (int i = 1; i < MON_DELAY; i++) begin
					mon_dly_q[i] <= mon_dly_q[i-1];
				end
				mon_out_q <= mon_dly_q[MON_DELAY-1];
			end
		end
	end
endmodule : smux_audio_path

// >>> sample_fifo.sv
// Purpose: Sample buffer between the host stream checker and frame assembly
// Assumes: One clock; read data comes from an output register
// Notes: Parameters WIDTH and DEPTH shape the storage; DEPTH is a power of two
`timescale 1ns/100ps
module sample_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	input wire logic [WIDTH-1:0] wr_data_in,
	output logic rd_valid_out,
	input wire logic rd_ready_in,
	output logic [WIDTH-1:0] rd_data_out
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_ptr_q;
	logic [AW:0] rd_ptr_q;
	logic [WIDTH-1:0] out_data_q;
	logic out_valid_q;

	wire logic mem_empty = (wr_ptr_q == rd_ptr_q);
	wire logic mem_full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
	wire logic do_wr = wr_valid_in && !mem_full;
	wire logic do_load = !mem_empty && (!out_valid_q || rd_ready_in);

	assign wr_ready_out = !mem_full;
	assign rd_valid_out = out_valid_q;
	assign rd_data_out = out_data_q;

	always_ff @(posedge clk_in) begin
		if (do_wr) begin
			mem_q[wr_ptr_q[AW-1:0]] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			out_valid_q <= 1'b0;
			out_data_q <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (do_load) begin
				out_data_q <= mem_q[rd_ptr_q[AW-1:0]];
				rd_ptr_q <= rd_ptr_q + 1'b1;
				out_valid_q <= 1'b1;
			end else if (rd_ready_in) begin
				out_valid_q <= 1'b0;
			end
		end
	end
endmodule : sample_fifo

// >>> audio_gear_model.sv
// Purpose: Far-side audio gear: word clock and receiver samples
// Assumes: Word clock runs free at single-speed rate
// Notes: Data line changes every cycle between sample pulses
`timescale 1ns/100ps
module audio_gear #(
	parameter int WC_HALF = 100
) (
	input wire logic clk_in,
	input wire logic run_in,
	output logic word_clk_out,
	output logic mon_valid_out,
	output logic [23:0] mon_data_out
);
	int cnt_q = 0;
	logic [23:0] n_q = 24'h1;
	localparam int DIP_AT = 6;
	localparam int DIP_LEN = 3;
	// A short dip after each rise gives an early edge that must be refused
	wire logic dip = (cnt_q >= DIP_AT) && (cnt_q < DIP_AT + DIP_LEN);
	initial begin
		word_clk_out = 1'b0;
		mon_valid_out = 1'b0;
		mon_data_out = 24'h0;
	end
	always @(posedge clk_in) begin
		cnt_q <= (cnt_q == 2 * WC_HALF - 1) ? 0 : cnt_q + 1;
		word_clk_out <= #1 (cnt_q < WC_HALF) && !dip;
		if (run_in && cnt_q[2:0] == 3'h0) begin
			mon_valid_out <= #1 1'b1;
			mon_data_out <= #1 n_q;
			n_q <= n_q + 24'h1;
		end else begin
			mon_valid_out <= #1 1'b0;
			mon_data_out <= #1 ~mon_data_out;
		end
	end
endmodule : audio_gear

// >>> smux_audio_path_monitor.sv
// Purpose: Port checks of the audio path
// Assumes: One clock, reset active low
// Notes: Frame spacing counted in a small counter
`timescale 1ns/100ps
module smux_audio_path_monitor #(
	parameter int FRAME_MIN = 16
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic usb_ready_out,
	input wire logic usb_error_out,
	input wire logic [15:0] usb_error_count_out,
	input wire logic dropout_out,
	input wire logic [191:0] port_slots_out,
	input wire logic port_frame_out,
	input wire logic [95:0] aes_left_out,
	input wire logic [95:0] aes_right_out,
	input wire logic [1:0] rate_active_out,
	input wire logic mon_valid_in,
	input wire logic mon_valid_out,
	input wire logic underrun_out,
	input wire logic [23:0] mon_data_out
);
	int gap_q;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) gap_q <= 0;
		else if (port_frame_out) gap_q <= 0;
		else if (gap_q < FRAME_MIN) gap_q <= gap_q + 1;
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence s_frame;
		port_frame_out ##1 !port_frame_out;
	endsequence
	sequence s_fill;
		!usb_ready_out ##1 !dropout_out;
	endsequence
	property p_frame_pulse;
		port_frame_out |-> s_frame;
	endproperty
	a_frame_pulse: assert property (p_frame_pulse) else $error("frame pulse too long");
	property p_frame_gap;
		port_frame_out |-> gap_q >= FRAME_MIN - 1;
	endproperty
	a_frame_gap: assert property (p_frame_gap) else $error("frames too close");
	property p_rate_code;
		rate_active_out != 2'h3;
	endproperty
	a_rate_code: assert property (p_rate_code) else $error("bad rate code");
	property p_left;
		aes_left_out[47:24] == port_slots_out[71:48];
	endproperty
	a_left: assert property (p_left) else $error("line left wrong");
	property p_right;
		aes_right_out[95:72] == port_slots_out[191:168];
	endproperty
	a_right: assert property (p_right) else $error("line right wrong");
	property p_err_cnt;
		usb_error_out && $past(usb_error_count_out) != 16'hffff
			|-> usb_error_count_out == $past(usb_error_count_out) + 16'h1;
	endproperty
	a_err_cnt: assert property (p_err_cnt) else $error("error count not raised");
	property p_cnt_hold;
		!usb_error_out |-> $stable(usb_error_count_out);
	endproperty
	a_cnt_hold: assert property (p_cnt_hold) else $error("error count moved");
	property p_drop;
		dropout_out |-> s_fill;
	endproperty
	a_drop: assert property (p_drop) else $error("ready during refill");
	property p_mon;
		mon_valid_in |=> mon_valid_out;
	endproperty
	a_mon: assert property (p_mon) else $error("monitor valid late");
	property p_slots_hold;
		!port_frame_out |-> $stable(port_slots_out);
	endproperty
	a_slots_hold: assert property (p_slots_hold) else $error("slots moved between frames");
	property p_rate_hold;
		!port_frame_out |-> $stable(rate_active_out);
	endproperty
	a_rate_hold: assert property (p_rate_hold) else $error("rate moved inside a frame");
	property p_under;
		underrun_out |-> port_frame_out;
	endproperty
	a_under: assert property (p_under) else $error("underrun outside a frame");
	property p_mon_hold;
		!mon_valid_out |-> $stable(mon_data_out);
	endproperty
	a_mon_hold: assert property (p_mon_hold) else $error("monitor data moved without sample");
endmodule : smux_audio_path_monitor

// >>> tb.sv
// Purpose: Self-checking bench for the audio path
// Assumes: FRAME_MIN scaled to 16, word clock every 200 cycles
// Notes: Host words carry even parity and consecutive positions, except the parity test's bad word and the dropout test's position gap
`timescale 1ns/100ps
module tb;
	logic clk_in = 1'b0, rst_n_in = 1'b0, usb_valid_in = 1'b0, usb_parity_in = 1'b0;
	logic mon_run = 1'b0, drop_seen = 1'b0;
	logic [1:0] rate_sel_in = 2'h0;
	logic [23:0] usb_data_in = 24'h0;
	logic [7:0] pos_q = 8'h0;
	logic [15:0] cnt_exp = 16'h0;
	logic usb_ready_out, usb_error_out, dropout_out, underrun_out, port_frame_out;
	logic word_clk_in, mon_valid_in, mon_valid_out;
	logic [15:0] usb_error_count_out;
	logic [191:0] port_slots_out;
	logic [95:0] aes_left_out, aes_right_out;
	logic [1:0] rate_active_out;
	logic [23:0] mon_data_in, mon_data_out;
	int errors = 0, cmp_count = 0;
	initial forever #2 clk_in = ~clk_in;
	smux_audio_path #(.FRAME_MIN(16)) u_smux_audio_path (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.rate_sel_in(rate_sel_in), .word_clk_in(word_clk_in), .usb_valid_in(usb_valid_in),
		.usb_ready_out(usb_ready_out), .usb_data_in(usb_data_in), .usb_parity_in(usb_parity_in),
		.usb_pos_in(pos_q), .usb_error_out(usb_error_out), .dropout_out(dropout_out),
		.usb_error_count_out(usb_error_count_out), .underrun_out(underrun_out),
		.port_slots_out(port_slots_out), .port_frame_out(port_frame_out),
		.aes_left_out(aes_left_out), .aes_right_out(aes_right_out),
		.rate_active_out(rate_active_out), .mon_valid_in(mon_valid_in),
		.mon_data_in(mon_data_in), .mon_valid_out(mon_valid_out), .mon_data_out(mon_data_out));
	audio_gear u_audio_gear (.clk_in(clk_in), .run_in(mon_run), .word_clk_out(word_clk_in),
		.mon_valid_out(mon_valid_in), .mon_data_out(mon_data_in));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	task automatic timeout();
		errors++;
		$display("unexpected at %0t: wait ran out", $time);
		end_of_test();
	endtask : timeout
	task automatic wait_frame();
		int i;
		for (i = 0; i < 1000; i++) begin
			@(posedge clk_in);
			#1;
			if (port_frame_out === 1'b1) return;
		end
		timeout();
	endtask : wait_frame
	task automatic push(input logic [23:0] base, input int n, input logic bad);
		int i, k;
		logic ok;
		drop_seen = 1'b0;
		for (k = 0; k < n; k++) begin
			usb_valid_in = 1'b1;
			usb_data_in = base + 24'(k);
			usb_parity_in = ^usb_data_in ^ bad;
			i = 0;
			do begin
				// Ready is read mid-cycle, where it stands until the taking edge
				#1;
				ok = (usb_ready_out === 1'b1);
				@(posedge clk_in);
				#1;
				if (dropout_out === 1'b1) drop_seen = 1'b1;
				if (++i > 100) timeout();
			end while (!ok);
			pos_q = pos_q + 8'h1;
		end
		usb_valid_in = 1'b0;
	endtask : push
	task automatic t_mon();
		int i, k;
		mon_run = 1'b1;
		for (k = 0; k < 6; k++) begin
			i = 0;
			do begin
				@(posedge clk_in);
				#1;
				if (++i > 100) timeout();
			end while (mon_valid_out !== 1'b1);
			chk(mon_data_out, (k < 3) ? 24'h0 : 24'(k - 2));
		end
		mon_run = 1'b0;
		$display("monitor test done");
	endtask : t_mon
	task automatic t_rate(input logic [1:0] r);
		int k, s;
		logic [23:0] v;
		rate_sel_in = r;
		wait_frame();
		wait_frame();
		push(24'h10 * r + 24'h1, 8, 1'b0);
		wait_frame();
		chk(24'(rate_active_out), (r == 2'h3) ? 24'h0 : 24'(r));
		chk(24'(underrun_out), 24'h0);
		for (k = 0; k < 8; k++) begin
			// Code 3 is served as single rate
			s = (r == 2'h1) ? 2 * (k % 4) + k / 4 : (r == 2'h2) ? 4 * (k % 2) + k / 2 : k;
			chk(port_slots_out[24 * s +: 24], 24'h10 * r + 24'(k + 1));
			v = s[0] ? aes_right_out[24 * (s / 2) +: 24] : aes_left_out[24 * (s / 2) +: 24];
			chk(v, 24'h10 * r + 24'(k + 1));
		end
		$display("rate %0d test done", r);
	endtask : t_rate
	task automatic t_err();
		rate_sel_in = 2'h0;
		wait_frame();
		wait_frame();
		push(24'h5, 1, 1'b1);
		cnt_exp = cnt_exp + 16'h1;
		chk(24'(usb_error_out), 24'h1);
		chk(24'(usb_error_count_out), 24'(cnt_exp));
		@(posedge clk_in);
		#1;
		chk(24'(usb_error_out), 24'h0);
		push(24'h6, 1, 1'b0);
		wait_frame();
		chk(24'(underrun_out), 24'h1);
		chk(port_slots_out[23:0], 24'h0);
		chk(port_slots_out[47:24], 24'h6);
		$display("parity test done");
	endtask : t_err
	task automatic t_drop();
		wait_frame();
		pos_q = pos_q + 8'h2;
		push(24'h77, 6, 1'b0);
		chk(24'(drop_seen), 24'h1);
		wait_frame();
		chk(24'(underrun_out), 24'h0);
		chk(port_slots_out[47:24] | port_slots_out[23:0], 24'h0);
		chk(port_slots_out[71:48], 24'h77);
		chk(port_slots_out[191:168], 24'h7c);
		$display("dropout test done");
	endtask : t_drop
	initial begin
		repeat (6) @(posedge clk_in);
		#1;
		rst_n_in = 1'b1;
		t_mon();
		t_rate(2'h0);
		t_rate(2'h1);
		t_rate(2'h2);
		t_rate(2'h3);
		t_err();
		t_drop();
		end_of_test();
	end
endmodule : tb
bind smux_audio_path smux_audio_path_monitor #(.FRAME_MIN(FRAME_MIN)) u_smux_audio_path_monitor (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .usb_ready_out(usb_ready_out),
	.usb_error_out(usb_error_out), .usb_error_count_out(usb_error_count_out),
	.dropout_out(dropout_out), .port_slots_out(port_slots_out), .port_frame_out(port_frame_out),
	.aes_left_out(aes_left_out), .aes_right_out(aes_right_out),
	.rate_active_out(rate_active_out), .mon_valid_in(mon_valid_in),
	.mon_valid_out(mon_valid_out), .underrun_out(underrun_out),
	.mon_data_out(mon_data_out));
